// >>> uart_flow_power_irq_control.v
// Purpose: Flow control, echo blocking, sleep and interrupt logic of a UART
// Assumes: Receiver and shifter on i_clk_sys; pins are synchronised here
// Notes:   Host port is a plain address/strobe port; reads answer next edge
`timescale 1ns/1ps
`include "uart_fc_defs.vh"

////////////////////////////////////////////////////////////////////////////
// Character FIFO, flip-flop storage addressed by index
module char_fifo #(
  parameter W  = 8,
  parameter D  = 128,
  parameter AW = 7
) (
  input  wire          i_clk_sys,
  input  wire          i_nrst,
  input  wire          i_valid,
  input  wire [W-1:0]  i_data,
  output wire          o_ready,
  output wire          o_valid,
  output wire [W-1:0]  o_data,
  input  wire          i_ready,
  output wire [AW:0]   o_count
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;
  wire wr = i_valid & o_ready;
  wire rd = o_valid & i_ready;
  assign o_ready = (cnt_r != D[AW:0]);
  assign o_valid = (cnt_r != {(AW+1){1'b0}});
  assign o_data  = mem[rp_r];
  assign o_count = cnt_r;
  // Storage has no reset; only pointers and count need a defined value
  always @(posedge i_clk_sys) begin
    if (wr) begin
      mem[wp_r] <= i_data;
    end
  end
  // Pointers wrap naturally because depth is a power of two
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (wr) wp_r <= wp_r + 1'b1;
      if (rd) rp_r <= rp_r + 1'b1;
      if (wr & ~rd) cnt_r <= cnt_r + 1'b1;
      else if (rd & ~wr) cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module uart_flow_power_irq_control #(
  parameter AUTOSLP_CHARS = `AUTOSLP_CHARS
) (
  input  wire       i_clk_sys,
  input  wire       i_nrst,
  input  wire [4:0] i_reg_addr,
  input  wire       i_reg_wr,
  input  wire       i_reg_rd,
  input  wire [7:0] i_reg_wdata,
  output wire [7:0] o_reg_rdata,
  input  wire       i_rx_valid,
  input  wire [7:0] i_rx_data,
  output wire       o_rx_ready,
  output wire       o_tx_ready,
  output wire       o_tx_start,
  output wire [7:0] o_tx_data,
  input  wire       i_tx_busy,
  input  wire       i_bit_tick,
  input  wire       i_char_tick,
  input  wire       i_rx_pin,
  input  wire       i_cts_n,
  input  wire [3:0] i_gpio,
  input  wire [5:0] i_line_err,
  input  wire       i_clk_stable,
  input  wire       i_xtal_sel,
  output wire       o_rts_n,
  output wire       o_tx_dir,
  output wire       o_sleep,
  output wire       o_irq_n
);
  localparam ST_IDLE   = 2'd0;
  localparam ST_LAUNCH = 2'd1;
  localparam ST_SEND   = 2'd2;

  // Level code scaled to a FIFO count
  function [7:0] lvl8;
    input [3:0] l;
    begin
      lvl8 = {1'b0, l, 3'b000};
    end
  endfunction

  reg [7:0] irq_mask_r, isr_r, lsr_mask_r, spc_mask_r, spc_r;
  reg [7:0] sts_mask_r, sts_r, mode_ctrl_first_r, mode_ctrl_second_r, guard_r;
  reg [7:0] flow_r, flow_threshold_levels_r, trglvl_r;
  reg [7:0] res1_r, res2_r, pau1_r, pau2_r, rdata_r;
  reg [5:0] s1_r, s2_r, s3_r;
  reg       xoff_r, pend_r, pend_pau_r, redo_v_r;
  reg [7:0] pend_d_r, redo_d_r;
  reg       rx_halt_r, rts_halt_r, ctl_pau_r;
  reg [1:0] ctl_left_r, st_r;
  reg [3:0] hold_r;
  reg       busy_d_r, clk_st_d_r, auto_r, init_done_r;
  reg [7:0] init_cnt_r;
  reg [16:0] slp_cnt_r;
  reg       start_r, rts_n_r, dir_r, sleep_r, irq_n_r;
  reg [7:0] txd_r;
  // Launch decisions are used by the level watch before they are built
  wire       go, ctl_go;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: rx, cts, gpio; third stage only feeds edge detect
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      s1_r <= 6'h3F;
      s2_r <= 6'h3F;
      s3_r <= 6'h3F;
    end else begin
      s1_r <= {i_rx_pin, i_cts_n, i_gpio};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  wire [5:0] pin_edge = s2_r ^ s3_r;
  wire       activity = |pin_edge;
  wire       cts_n_s  = s2_r[4];

  ////////////////////////////////////////////////////////////////////////
  // FIFOs
  wire       sleeping = mode_ctrl_first_r[`M1_SLEEP] | auto_r;
  wire       rx_sel   = (i_reg_addr == `ADR_DATA);
  wire       rxf_v, txf_v, rxf_wr, txf_pop;
  wire [7:0] rxf_d, txf_d, rxf_wd, rx_cnt, tx_cnt;
  wire       rx_pop = i_reg_rd & rx_sel & rxf_v;
  char_fifo #(.W(8), .D(128), .AW(7)) u_rxf (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_valid   (rxf_wr),
    .i_data    (rxf_wd),
    .o_ready   (o_rx_ready),
    .o_valid   (rxf_v),
    .o_data    (rxf_d),
    .i_ready   (rx_pop),
    .o_count   (rx_cnt)
  );
  char_fifo #(.W(8), .D(128), .AW(7)) u_txf (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_valid   (i_reg_wr & rx_sel),
    .i_data    (i_reg_wdata),
    .o_ready   (o_tx_ready),
    .o_valid   (txf_v),
    .o_data    (txf_d),
    .i_ready   (txf_pop),
    .o_count   (tx_cnt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Receive path: echo blocking and pause/resume filtering.
  // On a near miss the held first half is written and the new character is
  // replayed via redo, costing one extra cycle; input in that cycle is lost.
  wire [1:0] txm    = flow_r[5:4];
  wire [1:0] rxm    = flow_r[7:6];
  wire       sw_tx  = flow_r[`FC_SW_EN] & (txm != 2'b00);
  wire       sw_rx  = flow_r[`FC_SW_EN] & (rxm != 2'b00);
  wire       dual   = (txm == 2'b11);
  wire [7:0] p_one  = (txm == 2'b10) ? pau2_r : pau1_r;
  wire [7:0] r_one  = (txm == 2'b10) ? res2_r : res1_r;
  wire       echo_w = i_tx_busy | (hold_r != 4'h0);
  wire       cur_v  = redo_v_r | i_rx_valid;
  wire [7:0] cur_d  = redo_v_r ? redo_d_r : i_rx_data;
  wire       echo_x = mode_ctrl_second_r[`M2_ECHO] & echo_w;
  wire       take   = cur_v & ~sleeping & ~echo_x;
  reg        wr_c, wr_h, set_p, set_r, pend_nxt, redo_nxt;
  always @* begin
    wr_c = 1'b0;
    wr_h = 1'b0;
    set_p = 1'b0;
    set_r = 1'b0;
    pend_nxt = pend_r;
    redo_nxt = 1'b0;
    if (take) begin
      if (sw_tx & ~dual) begin
        if (cur_d == p_one) set_p = 1'b1;
        else if (cur_d == r_one) set_r = 1'b1;
        else wr_c = 1'b1;
      end else if (sw_tx & pend_r) begin
        pend_nxt = 1'b0;
        if (pend_pau_r & (cur_d == pau2_r)) set_p = 1'b1;
        else if (~pend_pau_r & (cur_d == res2_r)) set_r = 1'b1;
        else begin
          wr_h = 1'b1;
          redo_nxt = 1'b1;
        end
      end else if (sw_tx & ((cur_d == pau1_r) | (cur_d == res1_r))) begin
        pend_nxt = 1'b1;
      end else begin
        wr_c = 1'b1;
      end
    end
  end
  assign rxf_wr = wr_c | wr_h;
  assign rxf_wd = wr_h ? pend_d_r : cur_d;

  // Pause state and held character
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      xoff_r     <= 1'b0;
      pend_r     <= 1'b0;
      pend_pau_r <= 1'b0;
      pend_d_r   <= 8'h00;
      redo_v_r   <= 1'b0;
      redo_d_r   <= 8'h00;
    end else begin
      pend_r   <= sw_tx & pend_nxt;
      redo_v_r <= redo_nxt;
      redo_d_r <= cur_d;
      if (take & ~pend_r) begin
        pend_d_r   <= cur_d;
        pend_pau_r <= (cur_d == pau1_r);
      end
      if (!sw_tx) xoff_r <= 1'b0;
      else if (set_p) xoff_r <= 1'b1;
      else if (set_r) xoff_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive level watch: RTS hysteresis and pause/resume sending
  wire at_halt   = (rx_cnt >= lvl8(flow_threshold_levels_r[3:0]));
  wire at_resume = (rx_cnt <= lvl8(flow_threshold_levels_r[7:4]));
  wire need_ctl  = sw_rx & (ctl_left_r == 2'b00) &
                   (rx_halt_r ? at_resume : at_halt);
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      rts_halt_r <= 1'b0;
      rx_halt_r  <= 1'b0;
      ctl_left_r <= 2'b00;
      ctl_pau_r  <= 1'b0;
    end else begin
      // No interrupt source is tied to these crossings
      if (at_halt) rts_halt_r <= 1'b1;
      else if (at_resume) rts_halt_r <= 1'b0;
      if (!sw_rx) rx_halt_r <= 1'b0;
      if (need_ctl) begin
        rx_halt_r  <= ~rx_halt_r;
        ctl_pau_r  <= ~rx_halt_r;
        ctl_left_r <= (rxm == 2'b11) ? 2'b10 : 2'b01;
      end else if (ctl_go) begin
        ctl_left_r <= ctl_left_r - 2'b01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit launcher. Starts only between characters, so a CTS rise
  // mid-character lets the shifter finish before anything stops.
  wire [7:0] c_one = ctl_pau_r ? pau1_r : res1_r;
  wire [7:0] c_two = ctl_pau_r ? pau2_r : res2_r;
  wire       c_sec = (rxm == 2'b10) | ((rxm == 2'b11) & (ctl_left_r == 2'b01));
  wire [7:0] ctl_c = c_sec ? c_two : c_one;
  wire cts_ok = ~(flow_r[`FC_CTS] & cts_n_s);
  assign go     = (st_r == ST_IDLE) & ~i_tx_busy & ~sleeping &
                  ~mode_ctrl_first_r[`M1_TX_OFF] & cts_ok;
  assign ctl_go = go & (ctl_left_r != 2'b00);
  assign txf_pop = go & ~ctl_go & txf_v & ~(sw_tx & xoff_r);
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      st_r    <= ST_IDLE;
      start_r <= 1'b0;
      txd_r   <= 8'h00;
    end else begin
      start_r <= ctl_go | txf_pop;
      case (st_r)
        ST_IDLE: begin
          if (ctl_go | txf_pop) begin
            st_r  <= ST_LAUNCH;
            txd_r <= ctl_go ? ctl_c : txf_d;
          end
        end
        ST_LAUNCH: begin
          st_r <= ST_SEND;
        end
        ST_SEND: begin
          if (!i_tx_busy) st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end
  assign o_tx_start = start_r;
  assign o_tx_data  = txd_r;

  ////////////////////////////////////////////////////////////////////////
  // Guard time after the last stop bit, counted in bit ticks
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      busy_d_r <= 1'b0;
      hold_r   <= 4'h0;
    end else begin
      busy_d_r <= i_tx_busy;
      if (busy_d_r & ~i_tx_busy) hold_r <= guard_r[3:0];
      else if (i_bit_tick && hold_r != 4'h0) hold_r <= hold_r - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status sources and summary flags; a set always beats a read clear
  wire rd_isr = i_reg_rd & (i_reg_addr == `ADR_ISR);
  wire rd_spc = i_reg_rd & (i_reg_addr == `ADR_SPC);
  wire rd_sts = i_reg_rd & (i_reg_addr == `ADR_STS);
  wire rx_trg = (trglvl_r[7:4] != 4'h0) &
                (rx_cnt >= lvl8(trglvl_r[7:4]));
  wire tx_trg = (trglvl_r[3:0] != 4'h0) &
                (tx_cnt >= lvl8(trglvl_r[3:0]));
  wire clk_rdy = i_clk_stable & ~clk_st_d_r & i_xtal_sel;
  wire [7:0] isr_set = {
    pin_edge[4] & irq_mask_r[`ISR_CTS],
    ~rxf_v,
    ~txf_v,
    tx_trg,
    rx_trg,
    |(sts_r & sts_mask_r),
    |(spc_r & spc_mask_r),
    |({2'b00, i_line_err} & lsr_mask_r)
  };
  // CTS flag is sticky only while enabled; a clear enable forces it to 0
  wire [7:0] isr_keep = {irq_mask_r[`ISR_CTS], 2'b11, tx_trg, 4'hF};
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      isr_r      <= `ISR_RST;
      spc_r      <= `REG_RST;
      sts_r      <= `REG_RST;
      clk_st_d_r <= 1'b0;
    end else begin
      clk_st_d_r <= i_clk_stable;
      // Line-status sources stay levels; their masked summary is latched in bit 0
      isr_r <= (isr_r & isr_keep & ~{8{rd_isr}}) | isr_set;
      spc_r <= (spc_r & ~{8{rd_spc}}) | {6'h00, set_r, set_p};
      sts_r <= (sts_r & ~{8{rd_sts}}) | {2'b00, clk_rdy, 5'h00};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Autosleep: idle FIFOs, nothing pending, quiet pins for many chars
  wire pend_irq = |(isr_r & irq_mask_r);
  wire quiet = ~rxf_v & ~txf_v & ~pend_irq & ~activity;
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      slp_cnt_r <= 17'h0_0000;
      auto_r    <= 1'b0;
    end else if (!mode_ctrl_first_r[`M1_AUTOSLP] || !quiet) begin
      slp_cnt_r <= 17'h0_0000;
      auto_r    <= 1'b0;
    end else if (slp_cnt_r == AUTOSLP_CHARS[16:0]) begin
      auto_r <= 1'b1;
    end else if (i_char_tick) begin
      slp_cnt_r <= slp_cnt_r + 17'h0_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Init delay after reset holds the interrupt pin low
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      init_cnt_r  <= 8'h00;
      init_done_r <= 1'b0;
    end else if (init_cnt_r == `INIT_CYC) begin
      init_done_r <= 1'b1;
    end else begin
      init_cnt_r <= init_cnt_r + 8'h01;
    end
  end

  // Pin outputs, all from flops
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      rts_n_r <= 1'b0;
      dir_r   <= 1'b0;
      sleep_r <= 1'b0;
      irq_n_r <= 1'b0;
    end else begin
      rts_n_r <= flow_r[`FC_RTS] & rts_halt_r;
      dir_r   <= mode_ctrl_first_r[`M1_DIR_EN] & (echo_w | txf_v);
      sleep_r <= sleeping;
      irq_n_r <= init_done_r &
                 ~(mode_ctrl_first_r[`M1_IRQ_SEL] & pend_irq);
    end
  end
  assign o_rts_n = rts_n_r;
  assign o_tx_dir = dir_r;
  assign o_sleep = sleep_r;
  assign o_irq_n = irq_n_r;

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      irq_mask_r <= `REG_RST;
      lsr_mask_r <= `REG_RST;
      spc_mask_r <= `REG_RST;
      sts_mask_r <= `REG_RST;
      mode_ctrl_first_r    <= `REG_RST;
      mode_ctrl_second_r    <= `REG_RST;
      guard_r    <= `REG_RST;
      flow_r     <= `REG_RST;
      flow_threshold_levels_r  <= `REG_RST;
      trglvl_r   <= `REG_RST;
      res1_r     <= `REG_RST;
      res2_r     <= `REG_RST;
      pau1_r     <= `REG_RST;
      pau2_r     <= `REG_RST;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `ADR_IRQ_MASK: irq_mask_r <= i_reg_wdata;
        `ADR_LSR_MASK: lsr_mask_r <= i_reg_wdata;
        `ADR_SPC_MASK: spc_mask_r <= i_reg_wdata;
        `ADR_STS_MASK: sts_mask_r <= i_reg_wdata;
        `ADR_MODE_CTRL_FIRST:    mode_ctrl_first_r    <= i_reg_wdata;
        `ADR_MODE_CTRL_SECOND:    mode_ctrl_second_r    <= i_reg_wdata;
        `ADR_GUARD:    guard_r    <= i_reg_wdata;
        `ADR_FLOW:     flow_r     <= i_reg_wdata;
        `ADR_FLOW_THRESHOLD_LEVELS:  flow_threshold_levels_r  <= i_reg_wdata;
        `ADR_TRGLVL:   trglvl_r   <= i_reg_wdata;
        `ADR_RES1:     res1_r     <= i_reg_wdata;
        `ADR_RES2:     res2_r     <= i_reg_wdata;
        `ADR_PAU1:     pau1_r     <= i_reg_wdata;
        `ADR_PAU2:     pau2_r     <= i_reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Register reads, answered on the edge after the strobe
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      rdata_r <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `ADR_DATA:     rdata_r <= rxf_v ? rxf_d : 8'h00;
        `ADR_IRQ_MASK: rdata_r <= irq_mask_r;
        `ADR_ISR:      rdata_r <= isr_r;
        `ADR_LSR_MASK: rdata_r <= lsr_mask_r;
        `ADR_LSR:      rdata_r <= {cts_n_s, 1'b0, i_line_err};
        `ADR_SPC_MASK: rdata_r <= spc_mask_r;
        `ADR_SPC:      rdata_r <= spc_r;
        `ADR_STS_MASK: rdata_r <= sts_mask_r;
        `ADR_STS:      rdata_r <= sts_r;
        `ADR_MODE_CTRL_FIRST:    rdata_r <= mode_ctrl_first_r;
        `ADR_MODE_CTRL_SECOND:    rdata_r <= mode_ctrl_second_r;
        `ADR_GUARD:    rdata_r <= guard_r;
        `ADR_FLOW:     rdata_r <= flow_r;
        `ADR_FLOW_THRESHOLD_LEVELS:  rdata_r <= flow_threshold_levels_r;
        `ADR_TRGLVL:   rdata_r <= trglvl_r;
        `ADR_RES1:     rdata_r <= res1_r;
        `ADR_RES2:     rdata_r <= res2_r;
        `ADR_PAU1:     rdata_r <= pau1_r;
        `ADR_PAU2:     rdata_r <= pau2_r;
        default:       rdata_r <= 8'h00;
      endcase
    end
  end
  assign o_reg_rdata = rdata_r;
endmodule

// >>> uart_fc_defs.vh
// Purpose: Constants for the UART flow, power and interrupt control block
// Assumes: 5-bit register address on the host port, 8-bit registers
// Notes:   Levels are 4-bit codes scaled by eight against 128-deep FIFOs
`ifndef UART_FC_DEFS_VH
`define UART_FC_DEFS_VH
// Register offsets
`define ADR_DATA      5'h00
`define ADR_IRQ_MASK  5'h01
`define ADR_ISR       5'h02
`define ADR_LSR_MASK  5'h03
`define ADR_LSR       5'h04
`define ADR_SPC_MASK  5'h05
`define ADR_SPC       5'h06
`define ADR_STS_MASK  5'h07
`define ADR_STS       5'h08
`define ADR_MODE_CTRL_FIRST     5'h09
`define ADR_MODE_CTRL_SECOND     5'h0A
`define ADR_GUARD     5'h0B
`define ADR_FLOW      5'h0C
`define ADR_FLOW_THRESHOLD_LEVELS   5'h0D
`define ADR_TRGLVL    5'h0E
`define ADR_RES1      5'h10
`define ADR_RES2      5'h11
`define ADR_PAU1      5'h12
`define ADR_PAU2      5'h13
// Field positions
`define M1_TX_OFF     1
`define M1_DIR_EN     4
`define M1_SLEEP      5
`define M1_AUTOSLP    6
`define M1_IRQ_SEL    7
`define M2_ECHO       7
`define FC_RTS        0
`define FC_CTS        1
`define FC_SW_EN      3
`define ISR_CTS       7
`define STS_CLK_RDY   5
// Reset values
`define ISR_RST       8'h60
`define REG_RST       8'h00
// Timing
`define CLK_NS        10
`define INIT_NS       200
`define INIT_CYC      (`INIT_NS / `CLK_NS)
`define AUTOSLP_CHARS 65536
`endif

// >>> uart_fc_checker_assertions.sv
// Purpose: Port-level assertions for the UART flow, power and irq block
// Assumes: One clock, synchronous active-low reset
// Notes:   Register contents are hidden here, so checks use pins only
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module uart_fc_checker #(
  parameter AUTOSLP_CHARS = 65536
) (
  input wire       i_clk_sys,
  input wire       i_nrst,
  input wire [4:0] i_reg_addr,
  input wire       i_reg_rd,
  input wire [7:0] o_reg_rdata,
  input wire       o_rx_ready,
  input wire       o_tx_ready,
  input wire       o_tx_start,
  input wire [7:0] o_tx_data,
  input wire       i_tx_busy,
  input wire       o_rts_n,
  input wire       o_sleep,
  input wire       o_irq_n
);
  default clocking cb @(posedge i_clk_sys);
  endclocking

  // Reset checks are not disabled by reset, they watch it
  AST_RST_OUTS: assert property (!i_nrst |=> !o_tx_start && !o_sleep
    && !o_rts_n && o_rx_ready && o_tx_ready)
    else $error("outputs not at reset values");
  AST_RST_IRQ: assert property (!i_nrst |=> !o_irq_n)
    else $error("irq pin not low in reset");
  AST_INIT_HOLD: assert property ($rose(i_nrst) |-> !o_irq_n [*8])
    else $error("irq pin released before init done");

  // Launch pulse and shifter handshake
  AST_START_PULSE: assert property (disable iff (!i_nrst)
    o_tx_start |=> !o_tx_start)
    else $error("start pulse longer than one cycle");
  AST_NO_START_BUSY: assert property (disable iff (!i_nrst)
    i_tx_busy |-> !o_tx_start)
    else $error("launch while a character is in flight");
  AST_DATA_HOLD: assert property (disable iff (!i_nrst)
    !o_tx_start |-> $stable(o_tx_data))
    else $error("tx data changed without a launch");
  AST_SLEEP_HALT: assert property (disable iff (!i_nrst)
    o_sleep && $past(o_sleep) |-> !o_tx_start)
    else $error("launch while asleep");

  // Host port read data
  AST_RDATA_HOLD: assert property (disable iff (!i_nrst)
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");
  AST_UNMAPPED: assert property (disable iff (!i_nrst)
    i_reg_rd && i_reg_addr == 5'h1F |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind uart_flow_power_irq_control uart_fc_checker #(
  .AUTOSLP_CHARS(AUTOSLP_CHARS)
) i_chk (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
  .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_rx_ready(o_rx_ready),
  .o_tx_ready(o_tx_ready), .o_tx_start(o_tx_start), .o_tx_data(o_tx_data),
  .i_tx_busy(i_tx_busy), .o_rts_n(o_rts_n), .o_sleep(o_sleep),
  .o_irq_n(o_irq_n)
);

// >>> far_end_shifter.sv
// Purpose: Shifter and far-end model answering launch pulses
// Assumes: Launch pulse lasts one cycle
// Notes:   Character time varies so slow and prompt answers both occur
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module far_end_shifter #(
  parameter int CHAR_CYC = 30
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_start,
  input  wire logic [7:0] i_data,
  output logic            o_busy,
  output logic [7:0]      o_last,
  output int              o_done
);
  int         left;
  logic [7:0] sh;

  // Busy rises the cycle after a launch and stays up for the character
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_busy <= 1'b0;
      o_done <= 0;
      o_last <= 8'h00;
      left <= 0;
    end else if (i_start && !o_busy) begin
      o_busy <= 1'b1;
      sh <= i_data;
      left <= CHAR_CYC + $urandom_range(7);
    end else if (o_busy) begin
      left <= left - 1;
      if (left == 1) begin
        o_busy <= 1'b0;
        o_last <= sh;
        o_done <= o_done + 1;
      end
    end
  end
endmodule

// >>> uart_flow_power_irq_control_tb.sv
// Purpose: Self-checking bench for the UART flow, power and irq block
// Assumes: Far-end shifter model answers launches
// Notes:   Autosleep count shortened; outputs sampled on falling edges
`timescale 1ns/1ps
`include "uart_fc_defs.vh"
////////////////////////////////////////////////////////////////////////////
module uart_flow_power_irq_control_tb;
  logic       clk, nrst, wr, rd, rxv, rxpin, cts_n, bt, ct;
  logic [4:0] adr;
  logic [7:0] wd, rxd, rdata, txd, v, rs, ob, last;
  logic [5:0] lerr;
  wire        rx_rdy, tx_rdy, tx_st, busy, rts_n, sleep, irq_n;
  wire  [7:0] tx_data;
  int         err_count, samples_checked, done, n, tk;
  logic [7:0] q[$];

  uart_flow_power_irq_control #(.AUTOSLP_CHARS(4)) i_dut (
    .i_clk_sys(clk), .i_nrst(nrst), .i_reg_addr(adr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdata),
    .i_rx_valid(rxv), .i_rx_data(rxd), .o_rx_ready(rx_rdy),
    .o_tx_ready(tx_rdy), .o_tx_start(tx_st), .o_tx_data(tx_data),
    .i_tx_busy(busy), .i_bit_tick(bt), .i_char_tick(ct),
    .i_rx_pin(rxpin), .i_cts_n(cts_n), .i_gpio(4'h0), .i_line_err(lerr),
    .i_clk_stable(1'b1), .i_xtal_sel(1'b1), .o_rts_n(rts_n),
    .o_tx_dir(), .o_sleep(sleep), .o_irq_n(irq_n));
  far_end_shifter i_far (.i_clk_sys(clk), .i_nrst(nrst), .i_start(tx_st),
    .i_data(tx_data), .o_busy(busy), .o_last(last), .o_done(done));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, bit and character ticks, settled output snapshot
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    tk <= tk + 1;
    bt <= (tk % 4 == 0);
    ct <= (tk % 40 == 0);
  end
  always @(negedge clk) begin
    ob <= {3'b000, irq_n, sleep, rts_n, rx_rdy, tx_rdy};
    rs <= rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input [7:0] e, input [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Strobes drop for two or more edges between accesses so no signal is set twice
  task automatic wr_reg(input [4:0] a, input [7:0] d);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic rd_reg(input [4:0] a, input [7:0] e, input string nm);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    repeat (3) @(posedge clk);
    chk(nm, e, rs);
  endtask
  task automatic rx(input [7:0] d);
    rxd <= d;
    rxv <= 1'b1;
    rxpin <= ~rxpin;
    @(posedge clk);
    rxv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_done(input int want);
    for (int i = 0; i < 400 && done < want; i++) @(posedge clk);
    if (done < want) begin
      err_count++;
      $display("wrong value sent_count expected %0d seen %0d", want, done);
      test_done;
    end
  endtask
  task automatic wait_busy;
    for (int i = 0; i < 60 && busy !== 1'b1; i++) @(posedge clk);
    if (busy !== 1'b1) begin
      err_count++;
      $display("wrong value busy expected 1 seen %b", busy);
      test_done;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, wr, rd, rxv, cts_n, bt, ct, tk} = '0;
    rxpin = 1'b1;
    adr = 5'h00;
    wd = 8'h00;
    rxd = 8'h00;
    void'($urandom(50));
    lerr = 6'($urandom);
    repeat (20) @(posedge clk);
    chk("reset_pins", 8'h03, ob);
    nrst <= 1'b1;
    for (n = 0; n < 40 && ob[4] !== 1'b1; n++) @(posedge clk);
    chk("irq_init_hold", 8'h01, 8'(n > 19 && n < 40));
    if (n == 40) test_done;
    rd_reg(`ADR_ISR, 8'h60, "isr");
    rd_reg(5'h1F, 8'h00, "unmapped");
    rd_reg(`ADR_LSR, {2'b00, lerr}, "lsr");
    rd_reg(`ADR_LSR, {2'b00, lerr}, "lsr_kept");
    rd_reg(`ADR_STS, 8'h20, "clock_ready");
    rd_reg(`ADR_STS, 8'h00, "sts_cleared");
    // Fill to the pause level of 8, then drain to zero
    wr_reg(`ADR_MODE_CTRL_FIRST, 8'h80);
    wr_reg(`ADR_FLOW_THRESHOLD_LEVELS, 8'h01);
    wr_reg(`ADR_FLOW, 8'h01);
    for (int i = 0; i < 8; i++) begin
      q.push_back(8'($urandom));
      rx(q[$]);
      chk("rts_fill", 8'(i == 7), {7'h00, ob[2]});
    end
    for (int i = 0; i < 8; i++) begin
      rd_reg(`ADR_DATA, q.pop_front(), "rx_data");
      chk("rts_drain", 8'(i != 7), {7'h00, ob[2]});
    end
    // Transmitter off around the gating change, then gate on the pin
    wr_reg(`ADR_FLOW, 8'h00);
    wr_reg(`ADR_MODE_CTRL_FIRST, 8'h82);
    wr_reg(`ADR_FLOW, 8'h02);
    wr_reg(`ADR_MODE_CTRL_FIRST, 8'h80);
    cts_n <= 1'b1;
    // Let the pin pass its synchroniser before data is offered
    repeat (3) @(posedge clk);
    txd = 8'($urandom);
    v = 8'($urandom);
    wr_reg(`ADR_DATA, txd);
    repeat (30) @(posedge clk);
    chk("held_by_cts", 8'h00, 8'(done));
    cts_n <= 1'b0;
    wait_done(1);
    chk("tx_char", txd, last);
    // Stop request mid character: it finishes, the next one waits
    wr_reg(`ADR_DATA, txd);
    wr_reg(`ADR_DATA, v);
    wait_busy;
    cts_n <= 1'b1;
    wait_done(2);
    chk("finish_char", txd, last);
    repeat (40) @(posedge clk);
    chk("halt_after", 8'h02, 8'(done));
    cts_n <= 1'b0;
    wait_done(3);
    chk("resume_char", v, last);
    // CTS flag: held at zero while disabled, sticky and on the pin when on
    rd_reg(`ADR_ISR, 8'h60, "cts_flag_masked");
    wr_reg(`ADR_IRQ_MASK, 8'h80);
    cts_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("irq_pin_set", 8'h00, {7'h00, ob[4]});
    rd_reg(`ADR_ISR, 8'hE0, "cts_flag");
    chk("irq_pin_clear", 8'h01, {7'h00, ob[4]});
    wr_reg(`ADR_IRQ_MASK, 8'h00);
    // Echo during own transmission is dropped, later traffic is kept
    wr_reg(`ADR_FLOW, 8'h00);
    wr_reg(`ADR_MODE_CTRL_SECOND, 8'h80);
    wr_reg(`ADR_GUARD, 8'h04);
    wr_reg(`ADR_DATA, txd);
    wait_busy;
    rx(8'($urandom));
    wait_done(4);
    rx(8'($urandom));
    repeat (30) @(posedge clk);
    rx(v);
    rd_reg(`ADR_DATA, v, "after_echo");
    // Forced sleep: no reception and no launch until woken
    wr_reg(`ADR_MODE_CTRL_FIRST, 8'hA0);
    chk("sleep_pin", 8'h01, {7'h00, ob[3]});
    rx(8'($urandom));
    wr_reg(`ADR_DATA, txd);
    repeat (40) @(posedge clk);
    chk("no_tx_asleep", 8'h04, 8'(done));
    wr_reg(`ADR_MODE_CTRL_FIRST, 8'h80);
    rd_reg(`ADR_DATA, 8'h00, "rx_asleep");
    wait_done(5);
    test_done;
  end
endmodule
